/* File: hw/tvs_pkg.sv */
/*
 * Shared constants for the four-slot serial voice link: frame layout,
 * clock rates and reset values.
 * Assumes a single system clock on both ends of the link.
 */
package tvs_pkg;
    localparam int          SLOTS      = 4;
    localparam int          SLOT_BITS  = 16;
    localparam int          FRAME_BITS = SLOTS * SLOT_BITS;
    localparam int          CNT_W      = $clog2(FRAME_BITS);
    localparam int          SLOT_W     = $clog2(SLOTS);
    localparam int          CLK_HZ     = 25_000_000;
    localparam int          BCLK_HZ    = 512_000;
    localparam int          FS_HZ      = 8_000;
    localparam int          ACC_W      = 26;
    localparam logic [ACC_W-1:0] ACC_MOD  = ACC_W'(CLK_HZ);
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(2 * BCLK_HZ);
    localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(FRAME_BITS - 1);
    localparam logic [CNT_W-1:0] BIT_IDLE = CNT_W'(FRAME_BITS - 2);
    localparam logic [3:0]       WORD_END = 4'(SLOT_BITS - 1);
    localparam logic [ACC_W-1:0] ACC_RST  = 26'h0000000;
endpackage : tvs_pkg

/* File: hw/tvs_link_if.sv */
/*
 * The four link wires between the timing master and the DSP.
 * Assumes the bench instantiates it once and joins both ends to it.
 */
`timescale 1ns/1ps
`default_nettype none
interface tvs_link_if;
    logic bclk;
    logic fsync;
    logic sdo_master;
    logic sdo_dsp;
    modport master (output bclk, output fsync, output sdo_master, input sdo_dsp);
    modport dsp    (input bclk, input fsync, input sdo_master, output sdo_dsp);
endinterface : tvs_link_if
`default_nettype wire

/* File: hw/tvs_master.sv */
/*
 * Timing-master end of the serial voice port: makes the bit clock and
 * frame sync, shifts a 64-bit frame out and collects one in.
 * Assumes the partner is a timing slave and the data input is asynchronous.
 */
// Operation
// R1 - Master drives the frame sync output
// R2 - Master drives the bit clock output
// R3 - Receive sample bits on serial input
// R4 - Shift sample bits onto serial output
// R5 - Both directions run together every frame
// R6 - Four slots per frame, both directions
// R7 - Sixteen bits per slot, 64 per frame
// R8 - Frame sync repeats at eight kilohertz
// R9 - Bit clock runs at 512 kilohertz
// R10 - DSP is slave, never drives clocks
// R11 - Sync one bit before slot zero; MSB first
// R12 - Drive on rising edge, sample on falling
`timescale 1ns/1ps
`default_nettype none
module tvs_master (
    input  wire logic                             clk,
    input  wire logic                             reset_n,
    input  wire logic                             enable,
    input  wire logic [tvs_pkg::FRAME_BITS-1:0]   tx_frame,
    output var  logic                             tx_frame_taken,
    output var  logic [tvs_pkg::FRAME_BITS-1:0]   rx_frame,
    output var  logic                             rx_frame_valid,
    output var  logic [tvs_pkg::SLOT_BITS-1:0]    rx_word,
    output var  logic [tvs_pkg::SLOT_W-1:0]       rx_word_slot,
    output var  logic                             rx_word_valid,
    output var  logic                             active,
    tvs_link_if.master                            link
);
    logic [tvs_pkg::ACC_W-1:0]      acc_q;
    logic [tvs_pkg::ACC_W-1:0]      acc_d;
    logic [tvs_pkg::ACC_W:0]        acc_sum;
    logic                           tick;
    logic                           rise;
    logic                           fall;
    logic                           bclk_q;
    logic                           bclk_d;
    logic                           fs_q;
    logic                           fs_d;
    logic                           sdo_q;
    logic                           sdo_d;
    logic [tvs_pkg::CNT_W-1:0]      bit_q;
    logic [tvs_pkg::CNT_W-1:0]      bit_d;
    logic [tvs_pkg::CNT_W-1:0]      bit_nxt;
    logic [tvs_pkg::FRAME_BITS-1:0] tx_sh_q;
    logic [tvs_pkg::FRAME_BITS-1:0] tx_sh_d;
    logic [tvs_pkg::FRAME_BITS-1:0] rx_sh_q;
    logic [tvs_pkg::FRAME_BITS-1:0] rx_sh_d;
    logic [tvs_pkg::FRAME_BITS-1:0] rx_frame_q;
    logic [tvs_pkg::FRAME_BITS-1:0] rx_frame_d;
    logic                           rx_fv_q;
    logic                           rx_fv_d;
    logic [tvs_pkg::SLOT_BITS-1:0]  rx_word_q;
    logic [tvs_pkg::SLOT_BITS-1:0]  rx_word_d;
    logic [tvs_pkg::SLOT_W-1:0]     rx_slot_q;
    logic [tvs_pkg::SLOT_W-1:0]     rx_slot_d;
    logic                           rx_wv_q;
    logic                           rx_wv_d;
    logic                           taken_q;
    logic                           taken_d;
    logic                           live_q;
    logic                           live_d;
    logic                           active_q;
    logic                           active_d;
    logic                           sdi_s1_q;
    logic                           sdi_s2_q;

    // Phase accumulator keeps the bit clock at its exact average rate;
    // a plain divider from 25 MHz cannot hit it, so edges jitter by one clk.
    // Disabling clears the phase so every start has the same first half period.
    always_comb begin
        acc_sum = {1'b0, acc_q} + {1'b0, tvs_pkg::ACC_STEP};
        tick    = 1'b0;
        acc_d   = acc_sum[tvs_pkg::ACC_W-1:0];
        if (acc_sum >= {1'b0, tvs_pkg::ACC_MOD}) begin // R9
            acc_d = acc_sum[tvs_pkg::ACC_W-1:0] - tvs_pkg::ACC_MOD;
            tick  = 1'b1;
        end
        if (!enable) begin
            acc_d = tvs_pkg::ACC_RST;
            tick  = 1'b0;
        end
        rise = tick & ~bclk_q;
        fall = tick & bclk_q;
    end

    // Frame sequencer: bit counter, transmit shift and receive shift.
    // Receive waits for the first bit 0 so a start-up never yields a bogus frame.
    always_comb begin
        bclk_d     = enable ? (bclk_q ^ tick) : 1'b0; // R2
        fs_d       = fs_q;
        sdo_d      = sdo_q;
        bit_d      = bit_q;
        bit_nxt    = bit_q + 1'b1;
        tx_sh_d    = tx_sh_q;
        rx_sh_d    = rx_sh_q;
        rx_frame_d = rx_frame_q;
        rx_fv_d    = 1'b0;
        rx_word_d  = rx_word_q;
        rx_slot_d  = rx_slot_q;
        rx_wv_d    = 1'b0;
        taken_d    = 1'b0;
        live_d     = live_q;
        active_d   = enable;
        if (!enable) begin
            fs_d   = 1'b0;
            sdo_d  = 1'b0;
            bit_d  = tvs_pkg::BIT_IDLE;
            live_d = 1'b0;
        end else if (rise) begin // R12
            bit_d = bit_nxt;
            fs_d  = (bit_nxt == tvs_pkg::BIT_LAST); // R1 R8 R11
            if (bit_nxt == '0) begin // R6 R7
                tx_sh_d = tx_frame;
                sdo_d   = tx_frame[tvs_pkg::FRAME_BITS-1]; // R4 R11
                taken_d = 1'b1;
                live_d  = 1'b1;
            end else begin
                tx_sh_d = {tx_sh_q[tvs_pkg::FRAME_BITS-2:0], 1'b0};
                sdo_d   = tx_sh_q[tvs_pkg::FRAME_BITS-2]; // R4
            end
        // Sample mid-bit, long after the partner's data has settled
        end else if (fall && live_q) begin // R12 R5
            rx_sh_d = {rx_sh_q[tvs_pkg::FRAME_BITS-2:0], sdi_s2_q}; // R3
            if (bit_q[3:0] == tvs_pkg::WORD_END) begin // R7
                rx_word_d = {rx_sh_q[tvs_pkg::SLOT_BITS-2:0], sdi_s2_q};
                rx_slot_d = bit_q[tvs_pkg::CNT_W-1:4]; // R6
                rx_wv_d   = 1'b1;
            end
            if (bit_q == tvs_pkg::BIT_LAST) begin
                rx_frame_d = {rx_sh_q[tvs_pkg::FRAME_BITS-2:0], sdi_s2_q};
                rx_fv_d    = 1'b1;
            end
        end
    end

    // Clock and frame state
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            acc_q      <= tvs_pkg::ACC_RST;
            bclk_q     <= 1'b0;
            fs_q       <= 1'b0;
            sdo_q      <= 1'b0;
            bit_q      <= tvs_pkg::BIT_IDLE;
            tx_sh_q    <= '0;
            rx_sh_q    <= '0;
            rx_frame_q <= '0;
            rx_fv_q    <= 1'b0;
            rx_word_q  <= '0;
            rx_slot_q  <= '0;
            rx_wv_q    <= 1'b0;
            taken_q    <= 1'b0;
            live_q     <= 1'b0;
        end else begin
            acc_q      <= acc_d;
            bclk_q     <= bclk_d;
            fs_q       <= fs_d;
            sdo_q      <= sdo_d;
            bit_q      <= bit_d;
            tx_sh_q    <= tx_sh_d;
            rx_sh_q    <= rx_sh_d;
            rx_frame_q <= rx_frame_d;
            rx_fv_q    <= rx_fv_d;
            rx_word_q  <= rx_word_d;
            rx_slot_q  <= rx_slot_d;
            rx_wv_q    <= rx_wv_d;
            taken_q    <= taken_d;
            live_q     <= live_d;
        end
    end

    // Status flop; lags enable by one clk, as the link pins do when enable falls
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            active_q <= 1'b0;
        end else begin
            active_q <= active_d;
        end
    end

    // Two-stage synchroniser: the partner's data is not timed by clk.
    // Only the second stage is read, so a metastable first stage never fans out.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sdi_s1_q <= 1'b0;
            sdi_s2_q <= 1'b0;
        end else begin
            sdi_s1_q <= link.sdo_dsp; // R3
            sdi_s2_q <= sdi_s1_q;
        end
    end

    // Link pins and user outputs come straight from flops
    assign link.bclk       = bclk_q; // R2
    assign link.fsync      = fs_q; // R1
    assign link.sdo_master = sdo_q; // R4
    assign tx_frame_taken  = taken_q;
    assign rx_frame        = rx_frame_q;
    assign rx_frame_valid  = rx_fv_q;
    assign rx_word         = rx_word_q;
    assign rx_word_slot    = rx_slot_q;
    assign rx_word_valid   = rx_wv_q;
    assign active          = active_q;
endmodule : tvs_master
`default_nettype wire

/* File: hw/tvs_dsp.sv */
/*
 * DSP end of the serial voice port: a timing slave that follows the
 * master's bit clock and frame sync and exchanges 64-bit frames.
 * Assumes all three link inputs are asynchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module tvs_dsp (
    input  wire logic                             clk,
    input  wire logic                             reset_n,
    input  wire logic [tvs_pkg::FRAME_BITS-1:0]   tx_frame,
    output var  logic                             tx_frame_taken,
    output var  logic [tvs_pkg::FRAME_BITS-1:0]   rx_frame,
    output var  logic                             rx_frame_valid,
    output var  logic [tvs_pkg::SLOT_BITS-1:0]    rx_word,
    output var  logic [tvs_pkg::SLOT_W-1:0]       rx_word_slot,
    output var  logic                             rx_word_valid,
    output var  logic                             locked,
    tvs_link_if.dsp                               link
);
    logic                           bclk_s1_q;
    logic                           bclk_s2_q;
    logic                           bclk_s3_q;
    logic                           fs_s1_q;
    logic                           fs_s2_q;
    logic                           din_s1_q;
    logic                           din_s2_q;
    logic                           rise;
    logic                           fall;
    logic                           armed_q;
    logic                           armed_d;
    logic                           lock_q;
    logic                           lock_d;
    logic                           sdo_q;
    logic                           sdo_d;
    logic [tvs_pkg::CNT_W-1:0]      bit_q;
    logic [tvs_pkg::CNT_W-1:0]      bit_d;
    logic [tvs_pkg::FRAME_BITS-1:0] tx_sh_q;
    logic [tvs_pkg::FRAME_BITS-1:0] tx_sh_d;
    logic [tvs_pkg::FRAME_BITS-1:0] rx_sh_q;
    logic [tvs_pkg::FRAME_BITS-1:0] rx_sh_d;
    logic [tvs_pkg::FRAME_BITS-1:0] rx_frame_q;
    logic [tvs_pkg::FRAME_BITS-1:0] rx_frame_d;
    logic                           rx_fv_q;
    logic                           rx_fv_d;
    logic [tvs_pkg::SLOT_BITS-1:0]  rx_word_q;
    logic [tvs_pkg::SLOT_BITS-1:0]  rx_word_d;
    logic [tvs_pkg::SLOT_W-1:0]     rx_slot_q;
    logic [tvs_pkg::SLOT_W-1:0]     rx_slot_d;
    logic                           rx_wv_q;
    logic                           rx_wv_d;
    logic                           taken_q;
    logic                           taken_d;

    // Only the data line is driven; clock and sync are inputs here. // R10
    always_comb begin
        rise       = bclk_s2_q & ~bclk_s3_q;
        fall       = ~bclk_s2_q & bclk_s3_q;
        armed_d    = armed_q;
        lock_d     = lock_q;
        sdo_d      = sdo_q;
        bit_d      = bit_q;
        tx_sh_d    = tx_sh_q;
        rx_sh_d    = rx_sh_q;
        rx_frame_d = rx_frame_q;
        rx_fv_d    = 1'b0;
        rx_word_d  = rx_word_q;
        rx_slot_d  = rx_slot_q;
        rx_wv_d    = 1'b0;
        taken_d    = 1'b0;
        if (rise) begin // R12
            if (armed_q) begin // R11
                armed_d = 1'b0;
                lock_d  = 1'b1;
                bit_d   = '0;
                tx_sh_d = tx_frame;
                sdo_d   = tx_frame[tvs_pkg::FRAME_BITS-1]; // R11 R5
                taken_d = 1'b1;
            end else if (lock_q) begin
                bit_d   = bit_q + 1'b1; // R6 R7
                tx_sh_d = {tx_sh_q[tvs_pkg::FRAME_BITS-2:0], 1'b0};
                sdo_d   = tx_sh_q[tvs_pkg::FRAME_BITS-2];
            end
        end else if (fall) begin // R12
            armed_d = fs_s2_q; // R11
            if (lock_q) begin
                rx_sh_d = {rx_sh_q[tvs_pkg::FRAME_BITS-2:0], din_s2_q}; // R5
                if (bit_q[3:0] == tvs_pkg::WORD_END) begin // R7
                    rx_word_d = {rx_sh_q[tvs_pkg::SLOT_BITS-2:0], din_s2_q};
                    rx_slot_d = bit_q[tvs_pkg::CNT_W-1:4]; // R6
                    rx_wv_d   = 1'b1;
                end
                if (bit_q == tvs_pkg::BIT_LAST) begin
                    rx_frame_d = {rx_sh_q[tvs_pkg::FRAME_BITS-2:0], din_s2_q};
                    rx_fv_d    = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            bclk_s1_q  <= 1'b0;
            bclk_s2_q  <= 1'b0;
            bclk_s3_q  <= 1'b0;
            fs_s1_q    <= 1'b0;
            fs_s2_q    <= 1'b0;
            din_s1_q   <= 1'b0;
            din_s2_q   <= 1'b0;
            armed_q    <= 1'b0;
            lock_q     <= 1'b0;
            sdo_q      <= 1'b0;
            bit_q      <= '0;
            tx_sh_q    <= '0;
            rx_sh_q    <= '0;
            rx_frame_q <= '0;
            rx_fv_q    <= 1'b0;
            rx_word_q  <= '0;
            rx_slot_q  <= '0;
            rx_wv_q    <= 1'b0;
            taken_q    <= 1'b0;
        end else begin
            bclk_s1_q  <= link.bclk;
            bclk_s2_q  <= bclk_s1_q;
            bclk_s3_q  <= bclk_s2_q;
            fs_s1_q    <= link.fsync;
            fs_s2_q    <= fs_s1_q;
            din_s1_q   <= link.sdo_master;
            din_s2_q   <= din_s1_q;
            armed_q    <= armed_d;
            lock_q     <= lock_d;
            sdo_q      <= sdo_d;
            bit_q      <= bit_d;
            tx_sh_q    <= tx_sh_d;
            rx_sh_q    <= rx_sh_d;
            rx_frame_q <= rx_frame_d;
            rx_fv_q    <= rx_fv_d;
            rx_word_q  <= rx_word_d;
            rx_slot_q  <= rx_slot_d;
            rx_wv_q    <= rx_wv_d;
            taken_q    <= taken_d;
        end
    end

    assign link.sdo_dsp   = sdo_q;
    assign tx_frame_taken = taken_q;
    assign rx_frame       = rx_frame_q;
    assign rx_frame_valid = rx_fv_q;
    assign rx_word        = rx_word_q;
    assign rx_word_slot   = rx_slot_q;
    assign rx_word_valid  = rx_wv_q;
    assign locked         = lock_q;
endmodule : tvs_dsp
`default_nettype wire

/* File: test/tvs_link_asserts.sv */
/*
 * Concurrent checks on the four link wires of the serial voice port.
 * Assumes the bench instantiates it beside the link, on the master's clock.
 */
`timescale 1ns/1ps
`default_nettype none
module tvs_link_asserts (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic enable,
    input wire logic bclk,
    input wire logic fsync,
    input wire logic sdo_master,
    input wire logic sdo_dsp
);
    localparam int HALF_MIN  = 24;
    localparam int HALF_MAX  = 25;
    localparam int LAG_MAX   = 8;
    localparam int FRAME_CLK = tvs_pkg::CLK_HZ / tvs_pkg::FS_HZ;
    logic        bp_q, bp_d, fp_q, fp_d, arm_q, arm_d, seen_q, seen_d;
    logic        rise, fall, fs_rise;
    logic [7:0]  run_q, run_d, since_q, since_d;
    logic [11:0] fclk_q, fclk_d;
    logic [6:0]  rises_q, rises_d;

    // run_q, since_q and fclk_q saturate so a long idle never wraps into a false pass
    always_comb begin
        rise    = bclk && !bp_q;
        fall    = !bclk && bp_q;
        fs_rise = fsync && !fp_q;
        bp_d    = bclk;
        fp_d    = fsync;
        run_d   = (bclk != bp_q) ? 8'h01 : run_q + {7'h00, run_q != 8'hFF};
        since_d = rise ? 8'h00 : since_q + {7'h00, since_q != 8'hFF};
        arm_d   = enable && (arm_q || fall);
        seen_d  = enable && (seen_q || fs_rise);
        fclk_d  = fs_rise ? 12'h001 : fclk_q + {11'h000, fclk_q != 12'hFFF};
        rises_d = fs_rise ? 7'h00 : rises_q + {6'h00, rise};
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            {bp_q, fp_q, arm_q, seen_q} <= 4'h0;
            {run_q, since_q, fclk_q, rises_q} <= 35'h0;
        end else begin
            {bp_q, fp_q, arm_q, seen_q} <= {bp_d, fp_d, arm_d, seen_d};
            {run_q, since_q, fclk_q, rises_q} <= {run_d, since_d, fclk_d, rises_d};
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    chk_idle_silent: assert property ((!enable) [*2] |-> !bclk && !fsync && !sdo_master)
        else $error("link outputs not quiet while disabled");
    chk_high_half: assert property (fall && enable && $past(enable) |-> run_q inside {[HALF_MIN:HALF_MAX]})
        else $error("bit clock high phase has wrong length");
    chk_low_half: assert property (rise && arm_q |-> run_q inside {[HALF_MIN:HALF_MAX]})
        else $error("bit clock low phase has wrong length");
    chk_first_sync: assert property (rise && !arm_q && enable |-> fsync)
        else $error("first bit clock edge without frame sync");
    chk_sync_on_rise: assert property ($changed(fsync) && enable && $past(enable) |-> rise)
        else $error("frame sync moved off a rising bit clock edge");
    chk_sync_one_bit: assert property (rise && $past(fsync) && enable |-> !fsync)
        else $error("frame sync longer than one bit");
    chk_frame_clks: assert property (fs_rise && seen_q |-> fclk_q == FRAME_CLK)
        else $error("frame period not at frame rate");
    chk_frame_bits: assert property (fs_rise && seen_q |-> rises_q == tvs_pkg::FRAME_BITS - 1)
        else $error("frame does not hold sixty-four bits");
    chk_tx_on_rise: assert property ($changed(sdo_master) && enable && $past(enable) |-> rise)
        else $error("master data moved off a rising edge");
    chk_dsp_lag: assert property ($changed(sdo_dsp) |-> since_q <= LAG_MAX)
        else $error("dsp data changed late in the bit");

    cover property (fs_rise && seen_q);
    cover property ($fell(enable) && arm_q);
    cover property ($changed(sdo_dsp));
endmodule : tvs_link_asserts
`default_nettype wire

/* File: test/tdm_voice_serial_port_master_tb.sv */
/*
 * Bench joining the master and dsp ends over one link: frame table, abort, reset.
 * Assumes both ends share clk; stimulus changes on the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
module tdm_voice_serial_port_master_tb;
    typedef struct packed { logic [63:0] m_tx; logic [63:0] d_tx; } tvs_row_s;
    localparam int ROWS = 5;
    tvs_row_s    rows [ROWS] = '{'{64'h0000_0000_0000_0000, 64'hFFFF_FFFF_FFFF_FFFF},
        '{64'h8000_0000_0000_0001, 64'h0001_0000_0000_8000},
        '{64'h5555_AAAA_5555_AAAA, 64'hAAAA_5555_AAAA_5555},
        '{64'h1234_5678_9ABC_DEF0, 64'h0FED_CBA9_8765_4321},
        '{64'hFFFF_0000_FFFF_0000, 64'h8001_7FFE_C003_3FFC}};
    logic        clk, reset_n, enable, chk_on, b_q;
    logic        m_taken, m_fv, m_wv, active, d_taken, d_fv, d_wv, locked;
    logic [63:0] m_tx, m_rx, d_tx, d_rx, ws_m, ws_d;
    logic [63:0] mq [$];
    logic [63:0] dq [$];
    logic [15:0] m_word, d_word;
    logic [1:0]  m_slot, d_slot, ms, ds;
    int          fails, comparisons, m_n, n0;

    tvs_link_if link ();
    tvs_master tvs_master_i (.clk(clk), .reset_n(reset_n), .enable(enable), .tx_frame(m_tx),
        .tx_frame_taken(m_taken), .rx_frame(m_rx), .rx_frame_valid(m_fv), .rx_word(m_word),
        .rx_word_slot(m_slot), .rx_word_valid(m_wv), .active(active), .link(link.master));
    tvs_dsp tvs_dsp_i (.clk(clk), .reset_n(reset_n), .tx_frame(d_tx),
        .tx_frame_taken(d_taken), .rx_frame(d_rx), .rx_frame_valid(d_fv), .rx_word(d_word),
        .rx_word_slot(d_slot), .rx_word_valid(d_wv), .locked(locked), .link(link.dsp));
    tvs_link_asserts tvs_link_asserts_i (.clk(clk), .reset_n(reset_n), .enable(enable),
        .bclk(link.bclk), .fsync(link.fsync), .sdo_master(link.sdo_master),
        .sdo_dsp(link.sdo_dsp));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    // Frames last 3125 clocks, so 4000 leaves margin without hiding a stall
    task automatic wait_for(input int which);
        int n;
        n = 0;
        @(posedge clk);
        while (((which == 0) ? m_taken : d_taken) !== 1'b1 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 4000) begin
            fails++;
            tally_and_finish();
        end
        @(negedge clk);
    endtask : wait_for

    // After a break the first frame may be partial, so checking resumes one frame later
    task automatic restart();
        wait_for(0);
        wait_for(1);
        mq.delete();
        dq.delete();
        chk_on = 1'b1;
        repeat (2) wait_for(0);
    endtask : restart

    always @(posedge clk) begin
        if (m_taken === 1'b1) begin
            mq.push_back(m_tx);
            check(64'(link.sdo_master), 64'(m_tx[63]));
        end
        if (d_taken === 1'b1) dq.push_back(d_tx);
        if (link.bclk === 1'b0 && b_q === 1'b1) begin
            ws_m = {ws_m[62:0], link.sdo_master};
            ws_d = {ws_d[62:0], link.sdo_dsp};
            if (link.fsync === 1'b1 && chk_on && mq.size() > 0) check(ws_m, mq[0]);
            if (link.fsync === 1'b1 && chk_on && dq.size() > 0) check(ws_d, dq[0]);
        end
        b_q = link.bclk;
        if (d_wv === 1'b1) begin
            if (chk_on && mq.size() > 0) check(64'(d_word), 64'(mq[0][63 - 16 * ds -: 16]));
            if (chk_on && mq.size() > 0) check(64'(d_slot), 64'(ds));
            ds++;
        end
        if (d_fv === 1'b1) begin
            if (chk_on && mq.size() > 0) check(d_rx, mq[0]);
            if (mq.size() > 0) mq.pop_front();
            ds = 2'h0;
        end
        if (m_wv === 1'b1) begin
            if (chk_on && dq.size() > 0) check(64'(m_word), 64'(dq[0][63 - 16 * ms -: 16]));
            if (chk_on && dq.size() > 0) check(64'(m_slot), 64'(ms));
            ms++;
        end
        if (m_fv === 1'b1) begin
            m_n++;
            if (chk_on && dq.size() > 0) check(m_rx, dq[0]);
            if (dq.size() > 0) dq.pop_front();
            ms = 2'h0;
        end
    end

    initial begin
        {reset_n, enable, chk_on, b_q, ms, ds} = 8'h20;
        {m_tx, d_tx} = 128'h0;
        repeat (4) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        check(64'({active, locked}), 64'h0);
        for (int i = 0; i < ROWS; i++) begin
            m_tx = rows[i].m_tx;
            d_tx = rows[i].d_tx;
            enable = 1'b1;
            wait_for(0);
            wait_for(1);
        end
        check(64'(m_n), 64'(ROWS - 1));
        check(64'({active, locked}), 64'h3);
        repeat (900) @(negedge clk);
        enable = 1'b0;
        chk_on = 1'b0;
        n0 = m_n;
        repeat (300) @(negedge clk);
        check(64'(m_n), 64'(n0));
        check(64'({active, link.bclk, link.fsync}), 64'h0);
        enable = 1'b1;
        restart();
        repeat (1500) @(negedge clk);
        reset_n = 1'b0;
        chk_on = 1'b0;
        repeat (3) @(negedge clk);
        check(64'({m_taken, m_fv, m_wv, active, d_taken, d_fv, d_wv, locked}), 64'h0);
        reset_n = 1'b1;
        @(negedge clk);
        check(64'({locked, active, link.bclk, link.sdo_dsp}), 64'h4);
        restart();
        check(64'(locked), 64'h1);
        tally_and_finish();
    end
endmodule : tdm_voice_serial_port_master_tb
`default_nettype wire
